// [rcr_ctrl1.sv]
`timescale 1ns/1ps
// ============================================================================
// First control register of the clock: storage, crossing and decode.
// ============================================================================
module rcr_ctrl1
  import rcr_pkg::*;
#(
  parameter bit VARIANT_B = 1'b0
)(
  // Core clock and reset.
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Four-wire serial link.
  input  wire logic        sclk,
  input  wire logic        ce,
  input  wire logic        si,
  output logic             so,
  output logic             so_oe,
  // Neighbouring logic.
  input  wire logic        osc_halt_flag,
  input  wire logic        clkout_disable_a,
  input  wire logic        slow_clk_in,
  input  wire logic [5:0]  hour_count_bcd,
  // Slow clock open-drain pin.
  output logic             slow_clock_out_pin,
  output logic             slow_clock_out_oe,
  // Decoded control fields.
  output logic             weekly_alarm_enable,
  output logic             daily_alarm_enable,
  output logic             hour_24_mode,
  output logic             clkout_disable_b,
  output logic             spare_bit_three,
  output logic             test_mode,
  output logic [2:0]       periodic_sel,
  output rcr_rate_t        periodic_rate,
  output logic             periodic_level_form,
  output logic [5:0]       hour_coded
);

  // ==========================================================================
  // Serial front end on the link clock.
  // ==========================================================================
  rcr_ser_if link ();

  rcr_serial u_serial (
    .sclk  (sclk),
    .ce    (ce),
    .si    (si),
    .so    (so),
    .so_oe (so_oe),
    .bus   (link.ser)
  );

  // ==========================================================================
  // Synchronisers for the single-bit levels arriving from other clocks; address and data are held, not synchronised.
  // ==========================================================================
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic       halt_prev;
  logic       wr_prev;
  logic       ce_s;
  logic       halt_s;
  logic       slow_s;
  logic       wr_s;
  logic       halt_edge;
  logic       wr_edge;
  logic [7:0] ctrl;
  logic       clk_running;

  assign ce_s   = sync2[3];
  assign halt_s = sync2[2];
  assign slow_s = sync2[1];
  assign wr_s   = sync2[0];

  // Two flops per level; the first stage feeds only the second.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {ce, osc_halt_flag, slow_clk_in, link.wr_done};
      sync2 <= sync1;
    end
  end

  // Edge detection runs on the second stage only.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      halt_prev <= 1'b0;
      wr_prev   <= 1'b0;
    end else begin
      halt_prev <= halt_s;
      wr_prev   <= wr_s;
    end
  end

  assign halt_edge = halt_s && !halt_prev;
  assign wr_edge   = wr_s && !wr_prev;

  // ==========================================================================
  // The control word itself.
  // ==========================================================================
  // A halt edge in the same cycle as a write wins: the word must come up
  // clean after an oscillator stop, whatever the host was doing.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl <= CTRL1_RESET;
    end else if (halt_edge) begin
      ctrl <= CTRL1_RESET;
    end else if (wr_edge && link.wr_addr == CTRL1_ADDR) begin
      ctrl <= link.wr_data;
    end
  end

  // Read copy for the link. It is frozen while the frame select is high,
  // so the serial side sees a stable word without a per-bit crossing.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      link.rd_word <= CTRL1_RESET;
    end else if (!ce_s) begin
      link.rd_word <= ctrl;
    end
  end

  // ==========================================================================
  // Field decode.
  // ==========================================================================
  assign weekly_alarm_enable = ctrl[WEEK_EN_BIT];
  assign daily_alarm_enable  = ctrl[DAY_EN_BIT];
  assign hour_24_mode        = ctrl[HOUR24_BIT];
  assign test_mode           = ctrl[TEST_BIT];
  assign periodic_sel        = ctrl[PSEL_HI:PSEL_LO];
  assign clkout_disable_b    = VARIANT_B ? 1'b0 : ctrl[CLKDIS_BIT];
  assign spare_bit_three     = VARIANT_B ? ctrl[CLKDIS_BIT] : 1'b0;

  // Rate and waveform follow the selector one cycle later.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      periodic_rate       <= RATE_OFF;
      periodic_level_form <= 1'b0;
    end else begin
      periodic_rate       <= rcr_rate_t'(ctrl[PSEL_HI:PSEL_LO]);
      periodic_level_form <= ctrl[PSEL_HI:PSEL_LO] >= PSEL_LEVEL_MIN;
    end
  end

  // Hour presentation. The stored 24-hour count is recoded every cycle,
  // so a change of the mode bit also applies to counts already stored.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hour_coded <= HOUR_MIDNIGHT;
    end else if (hour_24_mode) begin
      hour_coded <= hour_count_bcd;
    end else begin
      hour_coded <= rcr_hour_12h(hour_count_bcd);
    end
  end

  // ==========================================================================
  // Slow clock output, open drain: it only ever pulls low.
  // ==========================================================================
  // The B variant has no disable path at all.
  assign clk_running        = VARIANT_B ||
                              !(ctrl[CLKDIS_BIT] && clkout_disable_a);
  assign slow_clock_out_pin = 1'b0;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      slow_clock_out_oe <= 1'b0;
    end else begin
      slow_clock_out_oe <= clk_running && !slow_s;
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  a_halt_clears: assert property (@(posedge core_clk) disable iff (srst)
    halt_edge |=> ctrl == CTRL1_RESET && !weekly_alarm_enable)
    else $error("Halt edge did not clear the control word.");

  a_write_lands: assert property (@(posedge core_clk) disable iff (srst)
    (wr_edge && !halt_edge && link.wr_addr == CTRL1_ADDR)
    |=> ctrl == $past(link.wr_data))
    else $error("Write to the control word was lost.");

  a_other_addr: assert property (@(posedge core_clk) disable iff (srst)
    (wr_edge && !halt_edge && link.wr_addr != CTRL1_ADDR) |=> $stable(ctrl))
    else $error("Write to another address changed the control word.");

  a_alarm_enables: assert property (@(posedge core_clk) disable iff (srst)
    (wr_edge && !halt_edge && link.wr_addr == CTRL1_ADDR)
    |=> weekly_alarm_enable == $past(link.wr_data[WEEK_EN_BIT]) &&
        daily_alarm_enable == $past(link.wr_data[DAY_EN_BIT]))
    else $error("Alarm enables do not follow the written byte.");

  a_hour_mode: assert property (@(posedge core_clk) disable iff (srst)
    (hour_24_mode && $stable(hour_24_mode))
    |=> hour_coded == $past(hour_count_bcd))
    else $error("24-hour mode altered the hour code.");

  a_hour_noon: assert property (@(posedge core_clk) disable iff (srst)
    (!hour_24_mode && hour_count_bcd == 6'h12) |=> hour_coded == HOUR_NOON)
    else $error("Noon not coded as 32 in 12-hour mode.");

  a_clk_gated: assert property (@(posedge core_clk) disable iff (srst)
    (!VARIANT_B && ctrl[CLKDIS_BIT] && clkout_disable_a)
    |=> !slow_clock_out_oe)
    else $error("Slow clock pulled low while both disables are set.");

  a_clk_runs: assert property (@(posedge core_clk) disable iff (srst)
    (!ctrl[CLKDIS_BIT] && !slow_s) |=> slow_clock_out_oe)
    else $error("Slow clock held off while enabled.");

  a_level_form: assert property (@(posedge core_clk) disable iff (srst)
    (periodic_sel >= PSEL_LEVEL_MIN) |=> periodic_level_form)
    else $error("Level waveform not selected for a level code.");

  a_sel_reset: assert property (@(posedge core_clk) disable iff (srst)
    halt_edge |=> periodic_sel == 3'h0 ##1 periodic_rate == RATE_OFF)
    else $error("Periodic selector did not reset to zero.");

endmodule

// [rcr_host.sv]
`timescale 1ns/1ps
// ============================================================================
// Host side of the four-wire link: one command byte, then one data byte.
// ============================================================================
module rcr_host (
  // Link pins.
  output logic      sclk,
  output logic      ce,
  output logic      si,
  input  wire logic so,
  input  wire logic so_oe
);
  localparam realtime HALF = 7.5;

  // The shift clock stands still low outside frames.
  initial begin
    sclk = 1'b0;
    ce   = 1'b0;
    si   = 1'b0;
  end

  // Sends cmd then wdat MSB first; captures the data byte from so.
  // si changes only after a falling edge, so is sampled just before each rising edge of the data byte.
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wdat,
                       output logic [7:0] rdat);
    ce = 1'b1;
    #400;
    for (int i = 15; i >= 0; i--) begin
      si = (i > 7) ? cmd[i-8] : wdat[i];
      #(HALF);
      if (i < 8) begin
        // A released so line is worth nothing; flag it as unknown.
        rdat[i] = so_oe ? so : 1'bx;
      end
      sclk = 1'b1;
      #(HALF);
      sclk = 1'b0;
    end
    // Released data line shows the inverse, not the last bit.
    si = ~si;
    #500;
    ce = 1'b0;
    #400;
  endtask
endmodule

// [rcr_pkg.sv]
// ============================================================================
// Shared constants and types for the first control register block.
// ============================================================================
package rcr_pkg;

  // ==========================================================================
  // Register map and field layout.
  // ==========================================================================
  localparam logic [3:0] CTRL1_ADDR   = 4'he;
  localparam logic [7:0] CTRL1_RESET  = 8'h00;
  localparam int         WEEK_EN_BIT  = 7;
  localparam int         DAY_EN_BIT   = 6;
  localparam int         HOUR24_BIT   = 5;
  localparam int         CLKDIS_BIT   = 4;
  localparam int         TEST_BIT     = 3;
  localparam int         PSEL_HI      = 2;
  localparam int         PSEL_LO      = 0;

  // ==========================================================================
  // Serial command byte layout: address high nibble, then the read flag.
  // ==========================================================================
  localparam int         CMD_ADDR_HI  = 7;
  localparam int         CMD_ADDR_LO  = 4;
  localparam int         CMD_READ_BIT = 3;
  localparam logic [2:0] LAST_BIT     = 3'h7;

  // ==========================================================================
  // Hour coding constants.
  // ==========================================================================
  localparam logic [5:0] HOUR_MIDNIGHT = 6'h12;
  localparam logic [5:0] HOUR_NOON     = 6'h32;
  localparam logic [5:0] HOUR_PM_FLAG  = 6'h20;
  localparam logic [5:0] HOUR_TEN_BCD  = 6'h10;
  localparam logic [4:0] DEC_TEN       = 5'h0a;
  localparam logic [4:0] HALF_DAY      = 5'h0c;

  // Selector codes at or above this value give the level waveform.
  localparam logic [2:0] PSEL_LEVEL_MIN = 3'h4;

  // Periodic interrupt rate, in selector code order.
  typedef enum logic [2:0] {
    RATE_OFF,
    RATE_FIXED,
    RATE_2HZ_PULSE,
    RATE_1HZ_PULSE,
    RATE_1HZ_LEVEL,
    RATE_MINUTE_LEVEL,
    RATE_HOUR_LEVEL,
    RATE_MONTH_LEVEL
  } rcr_rate_t;

  // Serial frame phase.
  typedef enum logic [1:0] {
    SER_CMD,
    SER_DATA,
    SER_DONE
  } rcr_ser_state_t;

  // Converts a 24-hour BCD hour into the 12-hour code with the PM flag.
  function automatic logic [5:0] rcr_hour_12h(input logic [5:0] h24);
    logic [4:0] bin;
    logic [4:0] pm;
    bin = 5'(h24[5:4]) * DEC_TEN + 5'(h24[3:0]);
    pm  = bin - HALF_DAY;
    if (bin == 5'h00) begin
      return HOUR_MIDNIGHT;
    end else if (bin < HALF_DAY) begin
      return h24;
    end else if (bin == HALF_DAY) begin
      return HOUR_NOON;
    end else if (pm < DEC_TEN) begin
      return HOUR_PM_FLAG | {2'h0, pm[3:0]};
    end
    return HOUR_PM_FLAG | HOUR_TEN_BCD | {2'h0, 4'(pm - DEC_TEN)};
  endfunction

endpackage

// [rcr_ser_if.sv]
`timescale 1ns/1ps
// ============================================================================
// Carrier between the serial front end and the register core.
// ============================================================================
interface rcr_ser_if;
  logic       wr_done;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_word;

  modport ser  (output wr_done, output wr_addr, output wr_data,
                input rd_word);
  modport core (input wr_done, input wr_addr, input wr_data,
                output rd_word);
endinterface

// [rcr_serial.sv]
`timescale 1ns/1ps
// ============================================================================
// Serial front end, clocked by the shift clock of the four-wire link.
// ============================================================================
module rcr_serial
  import rcr_pkg::*;
(
  // Link pins.
  input  wire logic   sclk,
  input  wire logic   ce,
  input  wire logic   si,
  output logic        so,
  output logic        so_oe,
  // Register core side.
  rcr_ser_if.ser      bus
);

  rcr_ser_state_t state;
  logic [2:0]     cnt;
  logic [7:0]     shreg;
  logic [7:0]     next_byte;
  logic [7:0]     out_sh;
  logic           is_read;
  logic [3:0]     addr;
  logic [7:0]     wr_data;
  logic           wr_done;

  assign next_byte   = {shreg[6:0], si};
  assign bus.wr_addr = addr;
  assign bus.wr_data = wr_data;
  assign bus.wr_done = wr_done;
  assign so          = out_sh[7];

  // Frame sequencing. The clock may stop between frames, so the frame
  // select itself clears this state instead of a core-side reset.
  always_ff @(posedge sclk or negedge ce) begin
    if (!ce) begin
      state   <= SER_CMD;
      cnt     <= 3'h0;
      shreg   <= 8'h00;
      is_read <= 1'b0;
      wr_done <= 1'b0;
    end else begin
      shreg <= next_byte;
      cnt   <= cnt + 3'h1;
      if (cnt == LAST_BIT) begin
        unique case (state)
          SER_CMD: begin
            is_read <= next_byte[CMD_READ_BIT];
            state   <= SER_DATA;
          end
          SER_DATA: begin
            wr_done <= !is_read;
            state   <= SER_DONE;
          end
          SER_DONE: begin
            state <= SER_DONE;
          end
        endcase
      end
    end
  end

  // Address and write data are held past the frame end so the core can
  // take them after its synchroniser delay.
  always_ff @(posedge sclk) begin
    if (state == SER_CMD && cnt == LAST_BIT) begin
      addr <= next_byte[CMD_ADDR_HI:CMD_ADDR_LO];
    end
    if (state == SER_DATA && cnt == LAST_BIT && !is_read) begin
      wr_data <= next_byte;
    end
  end

  // Read shifter; unmapped addresses return zero.
  always_ff @(posedge sclk or negedge ce) begin
    if (!ce) begin
      out_sh <= 8'h00;
      so_oe  <= 1'b0;
    end else if (state == SER_CMD && cnt == LAST_BIT) begin
      out_sh <= (next_byte[CMD_ADDR_HI:CMD_ADDR_LO] == CTRL1_ADDR) ?
                bus.rd_word : 8'h00;
      so_oe  <= next_byte[CMD_READ_BIT];
    end else if (state == SER_DATA) begin
      out_sh <= {out_sh[6:0], 1'b0};
      if (cnt == LAST_BIT) begin
        so_oe <= 1'b0;
      end
    end
  end

  a_read_load: assert property (@(posedge sclk) disable iff (!ce)
    (state == SER_CMD && cnt == LAST_BIT && next_byte[CMD_READ_BIT] &&
     next_byte[CMD_ADDR_HI:CMD_ADDR_LO] == CTRL1_ADDR)
    |=> so == $past(bus.rd_word[7]) && so_oe)
    else $error("Read data not loaded from the control word.");

  // Checked on the falling edge: the host gives no seventeenth rising edge,
  // so a check one rising edge after the data byte would never complete.
  a_write_done: assert property (@(negedge sclk) disable iff (!ce)
    $rose(wr_done) |-> wr_data == shreg)
    else $error("Written byte not handed to the core.");

endmodule

// [test_rtc_control_register_one.sv]
`timescale 1ns/1ps
// ============================================================================
// Self-checking bench for the first control register.
// ============================================================================
module test_rtc_control_register_one import rcr_pkg::*;;
  logic        core_clk;
  logic        srst;
  logic        sclk;
  logic        ce;
  logic        si;
  logic        so;
  logic        so_oe;
  logic        osc_halt_flag;
  logic        clkout_disable_a;
  logic        slow_clk_in;
  logic [5:0]  hour_count_bcd;
  logic        slow_clock_out_pin;
  logic        slow_clock_out_oe;
  logic        weekly_alarm_enable;
  logic        daily_alarm_enable;
  logic        hour_24_mode;
  logic        clkout_disable_b;
  logic        spare_bit_three;
  logic        test_mode;
  logic [2:0]  periodic_sel;
  rcr_rate_t   periodic_rate;
  logic        periodic_level_form;
  logic [5:0]  hour_coded;
  int          n_errors;
  int          checks_done;
  int          model;
  int          lows;
  logic [31:0] seed;
  logic [7:0]  r;
  int          lows_b;
  wire  [7:0]  b_f;
  wire         b_dis;
  wire         b_oe;

  rcr_ctrl1 i_rcr_ctrl1 (.core_clk(core_clk), .srst(srst), .sclk(sclk),
    .ce(ce), .si(si), .so(so), .so_oe(so_oe),
    .osc_halt_flag(osc_halt_flag), .clkout_disable_a(clkout_disable_a),
    .slow_clk_in(slow_clk_in), .hour_count_bcd(hour_count_bcd),
    .slow_clock_out_pin(slow_clock_out_pin),
    .slow_clock_out_oe(slow_clock_out_oe),
    .weekly_alarm_enable(weekly_alarm_enable),
    .daily_alarm_enable(daily_alarm_enable), .hour_24_mode(hour_24_mode),
    .clkout_disable_b(clkout_disable_b), .spare_bit_three(spare_bit_three),
    .test_mode(test_mode), .periodic_sel(periodic_sel),
    .periodic_rate(periodic_rate),
    .periodic_level_form(periodic_level_form), .hour_coded(hour_coded));

  rcr_host i_rcr_host (.sclk(sclk), .ce(ce), .si(si), .so(so),
    .so_oe(so_oe));

  // A B-variant device on the same link: bit 4 is a spare and the clock
  // output can never be switched off. Its fields, disable and clock output are compared; it is never read back.
  rcr_ctrl1 #(.VARIANT_B(1'b1)) i_rcr_ctrl1_b (.core_clk(core_clk),
    .srst(srst), .sclk(sclk), .ce(ce), .si(si), .so(), .so_oe(),
    .osc_halt_flag(osc_halt_flag), .clkout_disable_a(clkout_disable_a),
    .slow_clk_in(slow_clk_in), .hour_count_bcd(hour_count_bcd),
    .slow_clock_out_pin(), .slow_clock_out_oe(b_oe),
    .weekly_alarm_enable(b_f[7]), .daily_alarm_enable(b_f[6]),
    .hour_24_mode(b_f[5]), .clkout_disable_b(b_dis),
    .spare_bit_three(b_f[4]), .test_mode(b_f[3]), .periodic_sel(b_f[2:0]),
    .periodic_rate(), .periodic_level_form(), .hour_coded());

  // Core clock at 10 MHz and a 32.768 kHz source unrelated to it.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    slow_clk_in = 1'b0;
    forever #15259 slow_clk_in = ~slow_clk_in;
  end

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [5:0] bcd(input int v);
    return 6'((v / 10) * 16 + v % 10);
  endfunction

  // Twelve-hour code worked out from the hour table.
  function automatic logic [5:0] h12(input int h);
    if (h == 0) return 6'h12;
    if (h < 12) return bcd(h);
    if (h == 12) return 6'h32;
    return 6'h20 | bcd(h - 12);
  endfunction

  function automatic logic [7:0] fields();
    return {weekly_alarm_enable, daily_alarm_enable, hour_24_mode,
            clkout_disable_b, test_mode, periodic_sel};
  endfunction

  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp,
                           input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_pin(input logic [5:0] got, input logic [5:0] exp,
                           input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Frames end off the core clock; realign so inputs move just after edges.
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    i_rcr_host.frame({a, 4'h0}, d, dummy);
    if (a == CTRL1_ADDR) begin
      model = int'(d);
    end
    @(posedge core_clk);
    #1;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] q);
    i_rcr_host.frame({a, 4'h8}, 8'(xs()), q);
    @(posedge core_clk);
    #1;
  endtask

  task automatic check_all();
    logic [7:0] q;
    repeat (2) @(posedge core_clk);
    #1;
    check_reg(fields(), model[7:0], "fields");
    check_pin({5'h0, spare_bit_three}, 6'h00, "spare");
    check_reg({5'h0, periodic_rate}, {5'h0, model[2:0]}, "rate");
    check_pin({5'h0, periodic_level_form},
              {5'h0, model[2:0] >= PSEL_LEVEL_MIN}, "form");
    check_reg(b_f, model[7:0], "variant b fields");
    check_pin({5'h0, b_dis}, 6'h00, "variant b disable");
    reg_read(CTRL1_ADDR, q);
    check_reg(q, model[7:0], "readback");
  endtask

  task automatic results();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    srst = 1'b1;
    osc_halt_flag = 1'b0;
    clkout_disable_a = 1'b0;
    hour_count_bcd = 6'h00;
    seed = 32'haf8d;
    model = 0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge core_clk);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    check_pin(hour_coded, 6'h12, "hour after reset");
    check_all();
    // Random words, frames back to back.
    for (int i = 0; i < 20; i++) begin
      reg_write(CTRL1_ADDR, 8'(xs()));
      check_all();
    end
    // Every selector code once.
    for (int s = 0; s < 8; s++) begin
      reg_write(CTRL1_ADDR, 8'(s));
      check_all();
    end
    // Neighbouring addresses must not touch the word.
    reg_write(4'hd, 8'hff);
    check_all();
    reg_read(4'hf, r);
    check_reg(r, 8'h00, "other address");
    // Halt clears the control word in both devices; writes still land while the flag stays up.
    reg_write(CTRL1_ADDR, 8'hff);
    osc_halt_flag = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    model = 0;
    check_reg(fields(), 8'h00, "halt clear");
    check_reg(b_f, 8'h00, "variant b halt clear");
    reg_write(CTRL1_ADDR, 8'h5a);
    check_all();
    osc_halt_flag = 1'b0;
    // Mode goes in before any hour is presented.
    for (int m = 0; m < 2; m++) begin
      reg_write(CTRL1_ADDR, (m == 1) ? 8'h20 : 8'h00);
      for (int h = 0; h < 24; h++) begin
        hour_count_bcd = bcd(h);
        repeat (2) @(posedge core_clk);
        #1;
        check_pin(hour_coded, (m == 1) ? bcd(h) : h12(h), "hour");
      end
    end
    // Clock output stops only with both disable bits set.
    for (int k = 0; k < 4; k++) begin
      reg_write(CTRL1_ADDR, k[0] ? 8'h10 : 8'h00);
      clkout_disable_a = k[1];
      lows = 0;
      lows_b = 0;
      repeat (10) @(posedge core_clk);
      // Sample just after the edge, once the registered enables settle.
      repeat (700) begin
        @(posedge core_clk);
        #1;
        if (slow_clock_out_oe === 1'b1) lows++;
        if (b_oe === 1'b1) lows_b++;
      end
      check_pin({5'h0, lows > 0}, {5'h0, k != 3}, "clock out");
      check_pin({5'h0, lows_b > 0}, 6'h01, "variant b clock out");
      check_pin({5'h0, slow_clock_out_pin}, 6'h00, "pin level");
    end
    results();
  end

  // Whole run needs well under a millisecond of simulated time.
  initial begin
    #2000000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
endmodule
